//--- rtl/rxdsw_pkg.sv
// Constants, field layout and states of the receive descriptor engine
// Assumes a 32-bit host memory bus and a 32-bit register bus
package rxdsw_pkg;
    // ------------------------------------------------------------
    // Descriptor layout
    // ------------------------------------------------------------
    localparam int          OWN_BIT     = 31;
    localparam int          LEN_LSB     = 16;
    localparam int          LEN_W       = 15;
    localparam int          ES_BIT      = 15;
    localparam int          DE_BIT      = 14;
    localparam int          SRC_LSB     = 12;
    localparam int          RUNT_BIT    = 11;
    localparam int          MCAST_BIT   = 10;
    localparam int          WRAP_BIT    = 25;
    localparam int          CHAIN_BIT   = 24;
    localparam int          BS2_LSB     = 11;
    localparam int          BS_W        = 11;
    localparam int          POS_W       = 13;
    localparam logic [31:0] OFS_W1      = 32'h0000_0004;
    localparam logic [31:0] OFS_W2      = 32'h0000_0008;
    localparam logic [31:0] OFS_W3      = 32'h0000_000C;
    localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
    localparam logic [31:0] ALIGN_MASK  = 32'hFFFF_FFFC;
    localparam logic [14:0] RUNT_MIN    = 15'h0040;
    localparam logic [POS_W-1:0] WORD_BYTES = 13'h0004;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_POLL    = 8'h04;
    localparam logic [7:0]  REG_BASE    = 8'h08;
    localparam logic [7:0]  REG_CUR     = 8'h0C;
    localparam logic [7:0]  REG_ISTAT   = 8'h10;
    localparam logic [7:0]  REG_IMASK   = 8'h14;
    localparam int          CTRL_EN     = 0;
    localparam int          IRQ_W       = 3;
    localparam int          EV_DONE     = 0;
    localparam int          EV_UNAVAIL  = 1;
    localparam int          EV_TRUNC    = 2;
    // ------------------------------------------------------------
    // Engine states, Gray along the fetch/receive path
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_RD0   = 4'h1,
        ST_RD1   = 4'h3,
        ST_RD2   = 4'h2,
        ST_RD3   = 4'h6,
        ST_RECV  = 4'h7,
        ST_WDATA = 4'h5,
        ST_WSTAT = 4'h4
    } rxdsw_state_t;
endpackage

//--- rtl/rxdsw_stat_if.sv
// Frame summary passed from the engine to the status word composer
// Assumes both ends sit in the same clock domain
`timescale 1ns/100ps
interface rxdsw_stat_if;
    logic [14:0] frame_len;
    logic        overflow;
    logic        crc_err;
    logic        late_coll;
    logic        too_long;
    logic        trunc;
    logic [1:0]  src_type;
    logic        mcast;
    logic [31:0] word0;
    modport engine (output frame_len, overflow, crc_err, late_coll, too_long,
                    output trunc, src_type, mcast, input word0);
    modport comp   (input frame_len, overflow, crc_err, late_coll, too_long,
                    input trunc, src_type, mcast, output word0);
endinterface

//--- rtl/rxdsw_status.sv
// Builds the first descriptor word written back at the end of a frame
// Assumes the summary fields are held stable by the engine
`timescale 1ns/100ps
module rxdsw_status
    import rxdsw_pkg::*;
(
    // Frame summary in, status word out
    rxdsw_stat_if.comp st
);
    wire runt = st.frame_len < RUNT_MIN;
    wire err_sum = st.overflow | st.crc_err | st.late_coll
                 | st.too_long | runt | st.trunc;

    always_comb begin
        st.word0                        = '0;
        st.word0[OWN_BIT]               = 1'b0;
        st.word0[LEN_LSB+:LEN_W]        = st.frame_len;
        st.word0[ES_BIT]                = err_sum;
        st.word0[DE_BIT]                = st.trunc;
        st.word0[SRC_LSB+:2]            = st.src_type;
        st.word0[RUNT_BIT]              = runt;
        st.word0[MCAST_BIT]             = st.mcast;
        st.word0[ES_BIT-15]             = st.overflow;
        st.word0[ES_BIT-14]             = st.crc_err;
        st.word0[ES_BIT-9]              = st.late_coll;
        st.word0[ES_BIT-8]              = st.too_long;
    end
endmodule

//--- rtl/rxdsw_engine.sv
// Receive descriptor engine: fetches descriptors, stores frames, writes status
// Assumes a classic Wishbone register port and a classic Wishbone memory master
`timescale 1ns/100ps
// What this block does
// - Descriptor is four words: status, control, two buffers
// - Fill only descriptors whose ownership bit is set
// - Report frame length with CRC in 30:16
// - Bit 15 ORs overflow, CRC, collision, long, runt, truncation
// - Truncate oversized frame, set bit 14
// - Bits 13:12 give frame source type
// - Bit 11 marks frames under 64 bytes
// - Bit 10 marks multicast destination
// - Wrap bit returns to list base address
// - Chain bit uses buffer two as next; wrap wins
module rxdsw_engine
    import rxdsw_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Register port
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Host memory master
    output logic             m_cyc_o,
    output logic             m_stb_o,
    output logic             m_we_o,
    output logic [31:0]      m_adr_o,
    output logic [3:0]       m_sel_o,
    output logic [31:0]      m_dat_o,
    input  wire logic [31:0] m_dat_i,
    input  wire logic        m_ack_i,
    // Received byte stream with end-of-frame summary
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_last_i,
    input  wire logic        rx_overflow_i,
    input  wire logic        rx_crc_err_i,
    input  wire logic        rx_late_coll_i,
    input  wire logic        rx_too_long_i,
    input  wire logic [1:0]  rx_source_i,
    output logic             rx_ready_o,
    // Interrupt
    output logic             irq_o
);
    // ------------------------------------------------------------
    // Byte-lane merge, used by the base and interrupt mask registers
    // ------------------------------------------------------------
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b+:8] = new_v[8*b+:8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rxdsw_state_t      state;
    logic              enable;
    logic              poll_pend;
    logic [31:0]       base_addr;
    logic [31:0]       cur_addr;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    logic [31:0]       ctrl_word;
    logic [31:0]       buf1_addr;
    logic [31:0]       buf2_addr;
    logic [31:0]       pack;
    logic [1:0]        pack_cnt;
    logic [POS_W-1:0]  pos;
    logic              frame_end;
    logic              first_byte;
    logic [31:0]       bus_adr;
    logic [31:0]       bus_dat;
    rxdsw_stat_if      stat();

    rxdsw_status u_status (
        .st (stat)
    );

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    wire        wb_req   = wb_cyc_i & wb_stb_i;
    wire        wb_fire  = wb_req & wb_ack_o;
    wire        wr_fire  = wb_fire & wb_we_i;
    wire        wr_ctrl  = wr_fire && wb_adr_i == REG_CTRL;
    wire        wr_poll  = wr_fire && wb_adr_i == REG_POLL;
    wire        wr_base  = wr_fire && wb_adr_i == REG_BASE;
    wire        wr_imask = wr_fire && wb_adr_i == REG_IMASK;
    wire        rd_istat = wb_fire && !wb_we_i && wb_adr_i == REG_ISTAT;
    wire [31:0] base_new = lane_merge(base_addr, wb_dat_i, wb_sel_i) & ALIGN_MASK;
    wire [31:0] mask_new = lane_merge(32'(irq_mask), wb_dat_i, wb_sel_i);
    logic [31:0] rd_mux;

    always_comb begin
        case (wb_adr_i)
            REG_CTRL:  rd_mux = {31'h0, enable};
            REG_BASE:  rd_mux = base_addr;
            REG_CUR:   rd_mux = cur_addr;
            REG_ISTAT: rd_mux = {{(32-IRQ_W){1'b0}}, irq_stat};
            REG_IMASK: rd_mux = {{(32-IRQ_W){1'b0}}, irq_mask};
            default:   rd_mux = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // Descriptor decode
    // ------------------------------------------------------------
    wire [POS_W-1:0] size1 = POS_W'(ctrl_word[0+:BS_W]);
    wire [POS_W-1:0] size2 = POS_W'(ctrl_word[BS2_LSB+:BS_W]);
    wire             wrap  = ctrl_word[WRAP_BIT];
    wire             chain = ctrl_word[CHAIN_BIT];
    // In chained mode buffer two holds the link, so it carries no data
    wire [POS_W-1:0] cap   = chain ? size1 : size1 + size2;
    wire             room  = pos < cap;
    wire [31:0]      wr_adr = (pos < size1) ? buf1_addr + 32'(pos)
                                            : buf2_addr + 32'(pos - size1);
    wire [31:0]      next_desc = wrap  ? base_addr
                               : chain ? buf2_addr
                               : cur_addr + DESC_STRIDE;

    // ------------------------------------------------------------
    // Byte stream
    // ------------------------------------------------------------
    wire        in_recv  = state == ST_RECV;
    wire        take     = in_recv & rx_valid_i;
    wire [31:0] byte_pos = 32'(rx_data_i) << {pack_cnt, 3'b000};
    wire [31:0] next_pack = pack | byte_pos;
    wire        word_done = take & (pack_cnt == 2'h3 | rx_last_i);
    wire        bus_state = state inside {ST_RD0, ST_RD1, ST_RD2, ST_RD3, ST_WDATA, ST_WSTAT};
    wire        bus_done  = bus_state & m_ack_i;
    wire        ev_unavail = state == ST_RD0 & m_ack_i & ~m_dat_i[OWN_BIT];
    wire        ev_done    = state == ST_WSTAT & m_ack_i;
    wire        ev_trunc   = ev_done & stat.trunc;
    wire [IRQ_W-1:0] events = {ev_trunc, ev_unavail, ev_done};

    assign rx_ready_o = in_recv;
    assign m_cyc_o    = bus_state;
    assign m_stb_o    = bus_state;
    assign m_we_o     = state == ST_WDATA | state == ST_WSTAT;
    assign m_sel_o    = 4'hF;
    assign m_adr_o    = bus_adr;
    assign m_dat_o    = (state == ST_WSTAT) ? stat.word0 : bus_dat;
    assign irq_o      = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            enable   <= 1'b0;
            irq_mask <= '0;
            irq_stat <= '0;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            wb_dat_o <= rd_mux;
            if (wr_ctrl && wb_sel_i[0]) begin
                enable <= wb_dat_i[CTRL_EN];
            end
            if (wr_imask) begin
                irq_mask <= mask_new[IRQ_W-1:0];
            end
            // Clear only the bits the read returned; later events survive
            irq_stat <= (rd_istat ? irq_stat & ~wb_dat_o[IRQ_W-1:0] : irq_stat) | events;
        end
    end

    // ------------------------------------------------------------
    // Descriptor walk
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state     <= ST_IDLE;
            poll_pend <= 1'b0;
            base_addr <= 32'h0;
            cur_addr  <= 32'h0;
            ctrl_word <= 32'h0;
            buf1_addr <= 32'h0;
            buf2_addr <= 32'h0;
            bus_adr   <= 32'h0;
            bus_dat   <= 32'h0;
        end else begin
            if (wr_poll) begin
                poll_pend <= 1'b1;
            end
            if (wr_base) begin
                base_addr <= base_new;
                cur_addr  <= base_new;
            end
            case (state)
                ST_IDLE: begin
                    if (enable && poll_pend && !wr_base) begin
                        poll_pend <= wr_poll;
                        bus_adr   <= cur_addr;
                        state     <= ST_RD0;
                    end
                end
                ST_RD0: begin
                    if (m_ack_i) begin
                        if (m_dat_i[OWN_BIT]) begin
                            bus_adr <= cur_addr + OFS_W1;
                            state   <= ST_RD1;
                        end else begin
                            state   <= ST_IDLE;
                        end
                    end
                end
                ST_RD1: begin
                    if (m_ack_i) begin
                        ctrl_word <= m_dat_i;
                        bus_adr   <= cur_addr + OFS_W2;
                        state     <= ST_RD2;
                    end
                end
                ST_RD2: begin
                    if (m_ack_i) begin
                        buf1_addr <= m_dat_i & ALIGN_MASK;
                        bus_adr   <= cur_addr + OFS_W3;
                        state     <= ST_RD3;
                    end
                end
                ST_RD3: begin
                    if (m_ack_i) begin
                        buf2_addr <= m_dat_i & ALIGN_MASK;
                        state     <= ST_RECV;
                    end
                end
                ST_RECV: begin
                    if (word_done) begin
                        bus_adr <= room ? wr_adr : cur_addr;
                        bus_dat <= next_pack;
                        if (room) begin
                            state <= ST_WDATA;
                        end else if (rx_last_i) begin
                            bus_adr <= cur_addr;
                            state   <= ST_WSTAT;
                        end
                    end
                end
                ST_WDATA: begin
                    if (m_ack_i) begin
                        bus_adr <= cur_addr;
                        state   <= frame_end ? ST_WSTAT : ST_RECV;
                    end
                end
                ST_WSTAT: begin
                    if (m_ack_i) begin
                        if (!wr_base) begin
                            cur_addr <= next_desc;
                        end
                        // Keep walking the list until a host-owned word is met
                        poll_pend <= 1'b1;
                        state     <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Frame packing and summary
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pack           <= 32'h0;
            pack_cnt       <= 2'h0;
            pos            <= '0;
            frame_end      <= 1'b0;
            first_byte     <= 1'b1;
            stat.frame_len <= 15'h0;
            stat.overflow  <= 1'b0;
            stat.crc_err   <= 1'b0;
            stat.late_coll <= 1'b0;
            stat.too_long  <= 1'b0;
            stat.trunc     <= 1'b0;
            stat.src_type  <= 2'h0;
            stat.mcast     <= 1'b0;
        end else if (state == ST_RD3) begin
            pack           <= 32'h0;
            pack_cnt       <= 2'h0;
            pos            <= '0;
            frame_end      <= 1'b0;
            first_byte     <= 1'b1;
            stat.frame_len <= 15'h0;
            stat.trunc     <= 1'b0;
        end else begin
            if (take) begin
                stat.frame_len <= stat.frame_len + 15'h1;
                pack           <= word_done ? 32'h0 : next_pack;
                pack_cnt       <= word_done ? 2'h0 : pack_cnt + 2'h1;
                first_byte     <= 1'b0;
                if (first_byte) begin
                    stat.mcast <= rx_data_i[0];
                end
                if (word_done && !room) begin
                    stat.trunc <= 1'b1;
                end
                if (rx_last_i) begin
                    frame_end      <= 1'b1;
                    stat.overflow  <= rx_overflow_i;
                    stat.crc_err   <= rx_crc_err_i;
                    stat.late_coll <= rx_late_coll_i;
                    stat.too_long  <= rx_too_long_i;
                    stat.src_type  <= rx_source_i;
                end
            end
            if (state == ST_WDATA && bus_done) begin
                pos <= pos + WORD_BYTES;
            end
        end
    end
endmodule

//--- test/rxdsw_engine_properties.sv
// Port checker for the receive descriptor engine
// Assumes one clock domain; attached by the bind at the foot
`timescale 1ns/100ps
module rxdsw_engine_props (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    // Register port
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    // Memory master, byte stream and interrupt
    input wire logic        m_cyc_o,
    input wire logic        m_stb_o,
    input wire logic        m_we_o,
    input wire logic [31:0] m_adr_o,
    input wire logic [3:0]  m_sel_o,
    input wire logic [31:0] m_dat_o,
    input wire logic        m_ack_i,
    input wire logic        rx_valid_i,
    input wire logic        rx_last_i,
    input wire logic        rx_ready_o,
    input wire logic        irq_o
);
    // -----------------------------------------
    // Properties
    // -----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("register ack too long");
    property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("register ack late");
    property p_mem_hold; m_cyc_o && m_stb_o && !m_ack_i |=> m_cyc_o && m_stb_o && $stable(m_adr_o); endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped early");
    property p_wdat_hold; m_cyc_o && m_we_o && !m_ack_i |=> m_we_o && $stable(m_dat_o); endproperty
    a_wdat_hold: assert property (p_wdat_hold) else $error("write data moved");
    property p_sel_full; m_cyc_o |-> m_sel_o == 4'hF; endproperty
    a_sel_full: assert property (p_sel_full) else $error("partial word access");
    property p_ready_idle; rx_ready_o |-> !m_cyc_o; endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready during memory cycle");
    property p_ready_src; $rose(rx_ready_o) |-> $past(m_cyc_o && m_ack_i); endproperty
    a_ready_src: assert property (p_ready_src) else $error("ready without fetch");
    property p_last_wr; rx_valid_i && rx_ready_o && rx_last_i |-> ##[1:4] (m_cyc_o && m_we_o); endproperty
    a_last_wr: assert property (p_last_wr) else $error("no write after last byte");
    property p_irq_fall; $fell(irq_o) |-> $past(wb_ack_o); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped unprompted");
    property p_rst_quiet; $rose(reset_n_i) |-> !m_cyc_o && !rx_ready_o && !irq_o && !wb_ack_o; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
endmodule
bind rxdsw_engine rxdsw_engine_props u_props (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .m_cyc_o(m_cyc_o), .m_stb_o(m_stb_o), .m_we_o(m_we_o), .m_adr_o(m_adr_o), .m_sel_o(m_sel_o),
    .m_dat_o(m_dat_o), .m_ack_i(m_ack_i), .rx_valid_i(rx_valid_i), .rx_last_i(rx_last_i),
    .rx_ready_o(rx_ready_o), .irq_o(irq_o));

//--- test/rxdsw_mem_model.sv
// Host memory model answering classic Wishbone word requests
// Assumes the bench preloads descriptors and buffers through mem
`timescale 1ns/100ps
module rxdsw_mem_model (
    // Clock, reset and pacing
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        slow_i,
    // Memory slave port
    input  wire logic        m_cyc_i,
    input  wire logic        m_stb_i,
    input  wire logic        m_we_i,
    input  wire logic [31:0] m_adr_i,
    input  wire logic [3:0]  m_sel_i,
    input  wire logic [31:0] m_dat_i,
    output logic [31:0]      m_dat_o,
    output logic             m_ack_o
);
    logic [31:0] mem [0:1023];
    logic [1:0]  wait_cnt;
    wire         req = m_cyc_i && m_stb_i && !m_ack_o;
    wire         go  = req && (wait_cnt == 2'h0);
    wire  [9:0]  idx = m_adr_i[11:2];
    // Four-word descriptors and buffers share one word array
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            m_ack_o  <= 1'b0;
            wait_cnt <= 2'h0;
            m_dat_o  <= 32'h0;
        end else begin
            m_ack_o  <= go;
            wait_cnt <= (req && !go) ? wait_cnt - 2'h1 : {slow_i, slow_i};
            // Idle data toggles so a stale word never passes for an answer
            m_dat_o  <= go ? mem[idx] : ~m_dat_o;
            if (m_ack_o && m_we_i) begin
                for (int b = 0; b < 4; b++) if (m_sel_i[b]) mem[idx][8*b +: 8] <= m_dat_i[8*b +: 8];
            end
        end
    end
endmodule

//--- test/test_rxdsw.sv
// Testbench for the receive descriptor engine
// Assumes the memory model as host and the bound port checker
`timescale 1ns/100ps
`define CHECK(act, exp) begin checks_done++; if ((act) !== (exp)) begin miscompares++; \
    $display("MISMATCH t=%0t got %h want %h", $time, act, exp); end end
module test_rx_descriptor_status_writeback
    import rxdsw_pkg::*;
;
    logic        clk_i = 1'b0, reset_n_i = 1'b0, slow = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0]  wb_adr_i = 8'h00, rx_data_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, m_adr_o, m_dat_o, m_dat_i;
    logic        m_cyc_o, m_stb_o, m_we_o, m_ack_i, rx_ready_o, irq_o;
    logic [3:0]  m_sel_o, flags = 4'h0;
    logic        rx_valid_i = 1'b0, rx_last_i = 1'b0;
    logic [1:0]  rx_source_i = 2'b00;
    int          miscompares = 0, checks_done = 0, cycles = 0;
    rxdsw_engine dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .m_cyc_o(m_cyc_o), .m_stb_o(m_stb_o), .m_we_o(m_we_o), .m_adr_o(m_adr_o),
        .m_sel_o(m_sel_o), .m_dat_o(m_dat_o), .m_dat_i(m_dat_i), .m_ack_i(m_ack_i), .rx_valid_i(rx_valid_i),
        .rx_data_i(rx_data_i), .rx_last_i(rx_last_i), .rx_overflow_i(flags[3]), .rx_crc_err_i(flags[2]),
        .rx_late_coll_i(flags[1]), .rx_too_long_i(flags[0]), .rx_source_i(rx_source_i),
        .rx_ready_o(rx_ready_o), .irq_o(irq_o));
    rxdsw_mem_model u_mem (.clk_i(clk_i), .reset_n_i(reset_n_i), .slow_i(slow), .m_cyc_i(m_cyc_o),
        .m_stb_i(m_stb_o), .m_we_i(m_we_o), .m_adr_i(m_adr_o), .m_sel_i(m_sel_o), .m_dat_i(m_dat_o),
        .m_dat_o(m_dat_i), .m_ack_o(m_ack_i));
    // -----------------------------------------
    // Bus tasks and expectations
    // -----------------------------------------
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Ceiling well above the hundred or so cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic reg_acc(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask
    task automatic reg_wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] d;
        reg_acc(1'b1, adr, wd, d);
    endtask
    task automatic reg_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        reg_acc(1'b0, adr, 32'h0, d);
        `CHECK(d, exp)
    endtask
    task automatic irq_chk(input logic exp);
        @(negedge clk_i);
        `CHECK(irq_o, exp)
    endtask
    task automatic send_frame(input logic [7:0] b0, input int n, input logic [3:0] fl, input logic [1:0] src);
        @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            rx_valid_i  <= 1'b1;
            rx_data_i   <= b0 + 8'(i);
            rx_last_i   <= (i == n - 1);
            flags       <= fl;
            rx_source_i <= src;
            do @(posedge clk_i); while (rx_ready_o !== 1'b1);
        end
        rx_valid_i <= 1'b0;
        rx_last_i  <= 1'b0;
    endtask
    task automatic wait_returned(input logic [9:0] w);
        do @(posedge clk_i); while (u_mem.mem[w][OWN_BIT] !== 1'b0);
    endtask
    function automatic logic [31:0] exp_status(input logic [14:0] len, input logic de, input logic [3:0] fl,
                                               input logic [1:0] src, input logic mc);
        logic [31:0] w;
        w = 32'h0;
        w[LEN_LSB +: LEN_W] = len;
        w[DE_BIT] = de;
        w[SRC_LSB +: 2] = src;
        w[RUNT_BIT] = (len < RUNT_MIN);
        w[MCAST_BIT] = mc;
        {w[0], w[1], w[6], w[7]} = fl;
        w[ES_BIT] = (fl != 4'h0) || w[RUNT_BIT] || de;
        return w;
    endfunction
    // -----------------------------------------
    // Main sequence
    // -----------------------------------------
    initial begin
        for (int i = 0; i < 1024; i++) u_mem.mem[i] = 32'hDEAD_BEEF;
        // Two descriptors on word boundaries, the second wraps and chains
        u_mem.mem[64] = 32'h8000_0000;
        u_mem.mem[65] = 32'h0000_0040;
        u_mem.mem[66] = 32'h0000_0400;
        u_mem.mem[67] = 32'h0000_0000;
        u_mem.mem[68] = 32'h8000_0000;
        u_mem.mem[69] = 32'h0300_8004;
        u_mem.mem[70] = 32'h0000_0500;
        u_mem.mem[71] = 32'h0000_0600;
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        reg_chk(REG_ISTAT, 32'h0);
        reg_chk(REG_IMASK, 32'h0);
        reg_chk(8'h3C, 32'h0);
        reg_wr(REG_BASE, 32'h0000_0100);
        reg_wr(REG_IMASK, 32'h0000_0007);
        reg_wr(REG_CTRL, 32'h0000_0001);
        reg_wr(REG_POLL, 32'h0);
        send_frame(8'h01, 8, 4'b0100, 2'b01);
        wait_returned(10'd64);
        `CHECK(u_mem.mem[256], 32'h0403_0201)
        `CHECK(u_mem.mem[257], 32'h0807_0605)
        `CHECK(u_mem.mem[64], exp_status(15'd8, 1'b0, 4'b0100, 2'b01, 1'b1))
        reg_chk(REG_CUR, 32'h0000_0110);
        irq_chk(1'b1);
        reg_chk(REG_ISTAT, 32'h0000_0001);
        irq_chk(1'b0);
        slow <= 1'b1;
        send_frame(8'hAA, 6, 4'b1000, 2'b10);
        wait_returned(10'd68);
        slow <= 1'b0;
        `CHECK(u_mem.mem[320], 32'hADAC_ABAA)
        `CHECK(u_mem.mem[321], 32'hDEAD_BEEF)
        `CHECK(u_mem.mem[384], 32'hDEAD_BEEF)
        `CHECK(u_mem.mem[68], exp_status(15'd6, 1'b1, 4'b1000, 2'b10, 1'b0))
        reg_chk(REG_CUR, 32'h0000_0100);
        repeat (8) @(posedge clk_i);
        `CHECK(rx_ready_o, 1'b0)
        reg_wr(REG_IMASK, 32'h0);
        irq_chk(1'b0);
        reg_wr(REG_IMASK, 32'h0000_0007);
        irq_chk(1'b1);
        reg_chk(REG_ISTAT, 32'h0000_0007);
        irq_chk(1'b0);
        reg_chk(REG_ISTAT, 32'h0);
        stop_test();
    end
endmodule
